// >>> hw/lvp_ctrl.sv
// power management control: supply warning, low-voltage detect, stop mode select, axi4-lite slave
`timescale 1ns/1ps
// Function
// RULE_01: the warning flag sets when the supply falls below the warning level, including right after reset.
// RULE_02: writing one to the warning ack clears the flag only while no warning condition is present.
// RULE_03: an interrupt request is raised while the warning flag and its interrupt enable are both one.
// RULE_04: with detection and detect reset enabled, a detect event forces a full reset.
// RULE_05: with detection enabled, the detect stop enable decides whether detection stays active in stop.
// RULE_06: the detect enable turns detection on or off and gates the reset and stop enables.
// RULE_07: the reference buffer enable bit drives the reference buffer control output.
// RULE_08: the write-once bits accept only the first write after any reset.
// RULE_09: the deep stop select bit locks after its first write after power-on and only power-on unlocks it.
// RULE_10: the detect level select picks the detect trip setting and the warning range.
// RULE_11: the warning level select picks low or high warning level in the range and is freely writable.
// RULE_12: detect select and warning select form a two-bit warning level code with detect select as high bit.
// RULE_13: the partial power-down flag is read-only and sets on recovery from stop2.
// RULE_14: writing one to the partial power-down ack clears that flag.
// RULE_15: the deep stop select chooses stop3 at zero and stop2 at one.
// RULE_16: software should write both control registers once after reset to lock the write-once bits.
// RULE_17: the two ack bits act only on a written one and store nothing.
module lvp_ctrl
  import lvp_pkg::*;
(
  // clock and resets
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_por_b,
  // axi4-lite write channels
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read channels
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // comparator and power mode inputs
  input wire logic i_supply_warn,
  input wire logic i_supply_detect,
  input wire logic i_stop_mode,
  input wire logic i_stop2_recover,
  // control outputs
  output logic o_detect_active,
  output logic o_detect_reset,
  output logic o_reference_buffer_en,
  output logic o_deep_stop_select,
  output logic [1:0] o_warning_level_code,
  output logic o_detect_level_select,
  output logic o_supply_warning_irq,
  output logic o_irq
);
  // ***************
  // pin synchronisers
  // ***************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_stop2_recover, i_stop_mode, i_supply_detect, i_supply_warn};
      sync2_q <= sync1_q;
    end
  end
  // only the second stage feeds logic; the first may still be settling
  wire warn_s = sync2_q[0];
  wire detect_s = sync2_q[1];
  wire stop_s = sync2_q[2];
  wire recover_s = sync2_q[3];

  // ***************
  // axi4-lite write path
  // ***************
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  assign o_awready = !aw_held_q && !bvalid_q;
  assign o_wready = !w_held_q && !bvalid_q;
  wire aw_take = i_awvalid && o_awready;
  wire w_take = i_wvalid && o_wready;
  wire have_aw = aw_held_q || aw_take;
  wire have_w = w_held_q || w_take;
  wire wr_fire = have_aw && have_w && !bvalid_q;
  wire [7:0] wr_addr = aw_held_q ? aw_addr_q : i_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : i_wdata;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : i_wstrb;
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_c1 = wr_lane0 && (wr_addr == LVP_OFS_CTRL1);
  wire wr_c2 = wr_lane0 && (wr_addr == LVP_OFS_CTRL2);
  wire wr_iclr = wr_lane0 && (wr_addr == LVP_OFS_IRQ_CLR);
  wire wr_ien = wr_lane0 && (wr_addr == LVP_OFS_IRQ_EN);
  wire wr_map = (wr_addr == LVP_OFS_CTRL1) || (wr_addr == LVP_OFS_CTRL2) || (wr_addr == LVP_OFS_IRQ_STAT)
    || (wr_addr == LVP_OFS_IRQ_CLR) || (wr_addr == LVP_OFS_IRQ_EN);
  wire [7:0] wb = wr_data[7:0];

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= LVP_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? LVP_RESP_OKAY : LVP_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= i_awaddr;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          w_data_q <= i_wdata;
          w_strb_q <= i_wstrb;
        end
        if (bvalid_q && i_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  // ***************
  // control state
  // ***************
  logic warn_flag_q;
  logic warn_irq_en_q;
  logic det_rst_en_q;
  logic det_stop_en_q;
  logic det_en_q;
  logic ref_buf_en_q;
  logic det_lvl_q;
  logic warn_lvl_q;
  logic ppd_flag_q;
  logic deep_stop_q;
  logic c1_locked_q;
  logic c2_locked_q;
  logic deep_lock_q;
  logic warn_prev_q;
  logic recover_prev_q;

  wire warn_rise = warn_s && !warn_prev_q;
  wire recover_rise = recover_s && !recover_prev_q;
  // stop mode with the stop enable low switches detection off
  assign o_detect_active = det_en_q && (!stop_s || det_stop_en_q); // RULE_05 RULE_06
  wire detect_evt = o_detect_active && detect_s;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      warn_flag_q <= 1'b0;
      warn_prev_q <= 1'b0;
      recover_prev_q <= 1'b0;
      ppd_flag_q <= 1'b0;
    end else begin
      warn_prev_q <= warn_s;
      recover_prev_q <= recover_s;
      // a level already low after reset sets the flag too; set beats ack
      if (warn_s) begin
        warn_flag_q <= 1'b1; // RULE_01 RULE_02
      end else if (wr_c1 && wb[LVP_C1_WARN_ACK]) begin
        warn_flag_q <= 1'b0; // RULE_02 RULE_17
      end
      if (recover_s) begin
        ppd_flag_q <= 1'b1; // RULE_13
      end else if (wr_c2 && wb[LVP_C2_PPD_ACK]) begin
        ppd_flag_q <= 1'b0; // RULE_14 RULE_17
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      warn_irq_en_q <= LVP_RST_WARN_IRQ_EN;
      ref_buf_en_q <= LVP_RST_REF_BUF_EN;
      warn_lvl_q <= LVP_RST_WARN_LVL;
      det_rst_en_q <= LVP_RST_DET_RST_EN;
      det_stop_en_q <= LVP_RST_DET_STOP_EN;
      det_en_q <= LVP_RST_DET_EN;
      det_lvl_q <= LVP_RST_DET_LVL;
      c1_locked_q <= 1'b0;
      c2_locked_q <= 1'b0;
    end else begin
      // any lane-0 write locks, even one that repeats the reset values
      if (wr_c1) begin
        warn_irq_en_q <= wb[LVP_C1_WARN_IRQ_EN];
        ref_buf_en_q <= wb[LVP_C1_REF_BUF_EN];
        c1_locked_q <= 1'b1;
        if (!c1_locked_q) begin
          det_rst_en_q <= wb[LVP_C1_DET_RST_EN]; // RULE_08
          det_stop_en_q <= wb[LVP_C1_DET_STOP_EN]; // RULE_08
          det_en_q <= wb[LVP_C1_DET_EN]; // RULE_08
        end
      end
      if (wr_c2) begin
        warn_lvl_q <= wb[LVP_C2_WARN_LVL]; // RULE_11
        c2_locked_q <= 1'b1;
        if (!c2_locked_q) begin
          det_lvl_q <= wb[LVP_C2_DET_LVL]; // RULE_08
        end
      end
    end
  end

  // the deep stop bit lives in the power-on domain: system resets leave it and its lock alone
  always_ff @(posedge i_mclk or negedge i_por_b) begin
    if (!i_por_b) begin
      deep_stop_q <= LVP_RST_DEEP_STOP;
      deep_lock_q <= 1'b0;
    end else if (wr_c2 && !deep_lock_q) begin
      deep_stop_q <= wb[LVP_C2_DEEP_STOP]; // RULE_09 RULE_15
      deep_lock_q <= 1'b1; // RULE_09
    end
  end

  assign o_detect_reset = detect_evt && det_rst_en_q; // RULE_04
  assign o_reference_buffer_en = ref_buf_en_q; // RULE_07
  assign o_deep_stop_select = deep_stop_q; // RULE_15
  assign o_detect_level_select = det_lvl_q; // RULE_10
  assign o_warning_level_code = {det_lvl_q, warn_lvl_q}; // RULE_12
  assign o_supply_warning_irq = warn_flag_q && warn_irq_en_q; // RULE_03

  // ***************
  // sticky event status
  // ***************
  logic [LVP_EV_W-1:0] ev_stat_q;
  logic [LVP_EV_W-1:0] ev_en_q;
  wire [LVP_EV_W-1:0] ev_set = {recover_rise, detect_evt, warn_rise};
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ev_stat_q <= '0;
      ev_en_q <= '0;
    end else begin
      ev_stat_q <= ev_set | (ev_stat_q & ~(wr_iclr ? wb[LVP_EV_W-1:0] : '0));
      if (wr_ien) begin
        ev_en_q <= wb[LVP_EV_W-1:0];
      end
    end
  end
  assign o_irq = |(ev_stat_q & ev_en_q);

  // ***************
  // axi4-lite read path
  // ***************
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign o_arready = !rvalid_q;
  wire ar_take = i_arvalid && o_arready;
  wire [7:0] c1_val = {warn_flag_q, 1'b0, warn_irq_en_q, det_rst_en_q, det_stop_en_q, det_en_q, 1'b0, ref_buf_en_q};
  wire [7:0] c2_val = {2'b00, det_lvl_q, warn_lvl_q, ppd_flag_q, 2'b00, deep_stop_q};
  wire rd_hit_c1 = (i_araddr == LVP_OFS_CTRL1);
  wire rd_hit_c2 = (i_araddr == LVP_OFS_CTRL2);
  wire rd_hit_st = (i_araddr == LVP_OFS_IRQ_STAT);
  wire rd_hit_clr = (i_araddr == LVP_OFS_IRQ_CLR);
  wire rd_hit_en = (i_araddr == LVP_OFS_IRQ_EN);
  wire [7:0] rd_byte = rd_hit_c1 ? c1_val :
    rd_hit_c2 ? c2_val :
    rd_hit_st ? {5'b00000, ev_stat_q} :
    rd_hit_en ? {5'b00000, ev_en_q} : 8'h00;
  wire rd_map = rd_hit_c1 || rd_hit_c2 || rd_hit_st || rd_hit_clr || rd_hit_en;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= LVP_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_map ? LVP_RESP_OKAY : LVP_RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  // ***************
  // assertions
  // ***************
  a_warn_sets_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_01
    warn_s |=> warn_flag_q) else $error("warning flag not set");
  a_ack_blocked: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_02
    (warn_flag_q && warn_s) |=> warn_flag_q) else $error("flag cleared during warning");
  a_ack_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_02
    (wr_c1 && wb[LVP_C1_WARN_ACK] && !warn_s) |=> !warn_flag_q) else $error("ack failed");
  a_warn_irq: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_03
    (warn_s && warn_irq_en_q && !wr_c1) |=> o_supply_warning_irq) else $error("warning irq wrong");
  a_det_reset: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_04
    o_detect_reset |-> (det_en_q && det_rst_en_q && detect_s)) else $error("spurious detect reset");
  a_stop_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_05
    (stop_s && !det_stop_en_q) |-> !o_detect_active) else $error("detect active in stop");
  a_det_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_06
    !det_en_q |-> (!o_detect_active && !o_detect_reset)) else $error("detect not gated");
  a_once_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_08
    (wr_c1 && c1_locked_q) |=> $stable(det_en_q) && $stable(det_rst_en_q)) else $error("write-once changed");
  a_deep_lock: assert property (@(posedge i_mclk) disable iff (!i_por_b) // RULE_09
    deep_lock_q |=> $stable(deep_stop_q)) else $error("deep stop changed after lock");
  a_ppd_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_13
    recover_s |=> ppd_flag_q) else $error("ppd flag not set");
  a_ppd_ack: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_14
    (wr_c2 && wb[LVP_C2_PPD_ACK] && !recover_s) |=> !ppd_flag_q) else $error("ppd ack failed");
  a_read_ans: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ar_take |=> rvalid_q) else $error("read not answered");
  a_ref_buf: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_07
    wr_c1 |=> (o_reference_buffer_en == $past(wb[LVP_C1_REF_BUF_EN]))) else $error("ref buffer not written");
  a_warn_lvl_free: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_11
    wr_c2 |=> (warn_lvl_q == $past(wb[LVP_C2_WARN_LVL]))) else $error("warning level not written");
  a_lvl_once: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_08
    (wr_c2 && c2_locked_q) |=> $stable(det_lvl_q)) else $error("detect level changed after lock");
  a_stop_on: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_05
    (det_en_q && det_stop_en_q) |-> o_detect_active) else $error("detect off with stop enable");
  a_ppd_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_13
    (ppd_flag_q && !(wr_c2 && wb[LVP_C2_PPD_ACK])) |=> ppd_flag_q) else $error("ppd flag lost");
  a_ev_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (ev_stat_q[LVP_EV_WARN] && !wr_iclr) |=> ev_stat_q[LVP_EV_WARN]) else $error("warning status lost");
  c_warn_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_supply_warning_irq);
  c_det_rst: cover property (@(posedge i_mclk) disable iff (!i_rst_b) o_detect_reset);
  c_ppd_ack: cover property (@(posedge i_mclk) disable iff (!i_rst_b) ppd_flag_q ##1 !ppd_flag_q);
  c_deep_stop: cover property (@(posedge i_mclk) disable iff (!i_por_b) o_deep_stop_select);
endmodule

// >>> hw/lvp_pkg.sv
// package: register map, field positions, reset values and event bits of the power management block
package lvp_pkg;
  // ***************
  // register map
  // ***************
  localparam logic [7:0] LVP_OFS_CTRL1 = 8'h00;
  localparam logic [7:0] LVP_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] LVP_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] LVP_OFS_IRQ_CLR = 8'h0C;
  localparam logic [7:0] LVP_OFS_IRQ_EN = 8'h10;
  // ***************
  // control 1 fields
  // ***************
  localparam int LVP_C1_WARN_FLAG = 7;
  localparam int LVP_C1_WARN_ACK = 6;
  localparam int LVP_C1_WARN_IRQ_EN = 5;
  localparam int LVP_C1_DET_RST_EN = 4;
  localparam int LVP_C1_DET_STOP_EN = 3;
  localparam int LVP_C1_DET_EN = 2;
  localparam int LVP_C1_REF_BUF_EN = 0;
  // ***************
  // control 2 fields
  // ***************
  localparam int LVP_C2_DET_LVL = 5;
  localparam int LVP_C2_WARN_LVL = 4;
  localparam int LVP_C2_PPD_FLAG = 3;
  localparam int LVP_C2_PPD_ACK = 2;
  localparam int LVP_C2_DEEP_STOP = 0;
  // ***************
  // reset values of stored control bits
  // ***************
  localparam logic LVP_RST_WARN_IRQ_EN = 1'b0;
  localparam logic LVP_RST_DET_RST_EN = 1'b1;
  localparam logic LVP_RST_DET_STOP_EN = 1'b1;
  localparam logic LVP_RST_DET_EN = 1'b1;
  localparam logic LVP_RST_REF_BUF_EN = 1'b0;
  localparam logic LVP_RST_DET_LVL = 1'b0;
  localparam logic LVP_RST_WARN_LVL = 1'b0;
  localparam logic LVP_RST_DEEP_STOP = 1'b0;
  // ***************
  // event bits in the sticky interrupt status
  // ***************
  localparam int LVP_EV_WARN = 0;
  localparam int LVP_EV_DETECT = 1;
  localparam int LVP_EV_PPD = 2;
  localparam int LVP_EV_W = 3;
  localparam logic [1:0] LVP_RESP_OKAY = 2'b00;
  localparam logic [1:0] LVP_RESP_SLVERR = 2'b10;
endpackage

// >>> testbench/lvp_supply_model.sv
// supply comparator model: turns a supply voltage in millivolts into warning and detect levels
`timescale 1ns/1ps
module lvp_supply_model (
  // supply and level selects
  input wire logic [15:0] i_supply_mv,
  input wire logic [1:0] i_level_code,
  input wire logic i_detect_level_select,
  // comparator outputs
  output logic o_supply_warn,
  output logic o_supply_detect
);
  logic [15:0] warn_mv;
  logic [15:0] det_mv;
  // typical trip points only; no hysteresis, so a supply sitting on a trip point is not modelled
  assign warn_mv = (i_level_code == 2'b00) ? 16'h0AB4 : (i_level_code == 2'b01) ? 16'h0B68 :
                   (i_level_code == 2'b10) ? 16'h10CC : 16'h11F8;
  assign det_mv = i_detect_level_select ? 16'h0FA0 : 16'h0A00;
  assign o_supply_warn = i_supply_mv < warn_mv;
  assign o_supply_detect = i_supply_mv < det_mv;
endmodule

// >>> testbench/tb_top.sv
// testbench: register bus master, supply stimulus and checks of the power management block
`timescale 1ns/1ps
module tb_top;
  import lvp_pkg::*;
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_por_b = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0, i_stop_mode = 1'b0, i_stop2_recover = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic [15:0] supply_mv = 16'h0CE4;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, sup_warn, sup_det;
  logic o_detect_active, o_detect_reset, o_reference_buffer_en, o_deep_stop_select;
  logic o_detect_level_select, o_supply_warning_irq, o_irq;
  logic [1:0] o_bresp, o_rresp, o_warning_level_code, rs;
  logic [31:0] o_rdata, rd;
  logic lvl;
  logic [15:0] mv;
  int bad_count = 0, total_checks = 0;
  always #5 i_mclk = ~i_mclk;
  lvp_ctrl uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_por_b(i_por_b), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_supply_warn(sup_warn), .i_supply_detect(sup_det), .i_stop_mode(i_stop_mode),
    .i_stop2_recover(i_stop2_recover), .o_detect_active(o_detect_active), .o_detect_reset(o_detect_reset),
    .o_reference_buffer_en(o_reference_buffer_en), .o_deep_stop_select(o_deep_stop_select),
    .o_warning_level_code(o_warning_level_code), .o_detect_level_select(o_detect_level_select),
    .o_supply_warning_irq(o_supply_warning_irq), .o_irq(o_irq));
  lvp_supply_model supply (.i_supply_mv(supply_mv), .i_level_code(o_warning_level_code),
    .i_detect_level_select(o_detect_level_select), .o_supply_warn(sup_warn), .o_supply_detect(sup_det));
  // ***************
  // checking and closing
  // ***************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo;
    chk("bus_answer", 32'h0000_0000, 32'h0000_0001);
    close_out();
  endtask
  function automatic logic warn_exp(input logic [15:0] v, input logic [1:0] c);
    logic [15:0] t;
    case (c)
      2'b00: t = 16'h0AB4;
      2'b01: t = 16'h0B68;
      2'b10: t = 16'h10CC;
      default: t = 16'h11F8;
    endcase
    return v < t;
  endfunction
  // ***************
  // bus master and stimulus
  // ***************
  // handshakes are sampled at the falling edge, so they equal what the next rising edge sees
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, ha, hw, hb;
    aw = 1'b1;
    w = 1'b1;
    hb = 1'b0;
    @(posedge i_mclk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= {24'h00_0000, d};
    i_bready <= 1'b1;
    for (int n = 0; n < 40 && (aw || w); n++) begin
      @(negedge i_mclk);
      ha = aw && (o_awready === 1'b1);
      hw = w && (o_wready === 1'b1);
      @(posedge i_mclk);
      if (ha) begin
        i_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (hw) begin
        i_wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    if (aw || w) tmo();
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge i_mclk);
      hb = o_bvalid === 1'b1;
      rs = o_bresp;
      @(posedge i_mclk);
    end
    if (!hb) tmo();
    i_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ha, hr;
    ha = 1'b0;
    hr = 1'b0;
    @(posedge i_mclk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    for (int n = 0; n < 40 && !ha; n++) begin
      @(negedge i_mclk);
      ha = o_arready === 1'b1;
      @(posedge i_mclk);
    end
    if (!ha) tmo();
    i_arvalid <= 1'b0;
    for (int n = 0; n < 40 && !hr; n++) begin
      @(negedge i_mclk);
      hr = o_rvalid === 1'b1;
      rd = o_rdata;
      rs = o_rresp;
      @(posedge i_mclk);
    end
    if (!hr) tmo();
    i_rready <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic sup(input logic [15:0] v);
    @(posedge i_mclk);
    supply_mv <= v;
    settle(5);
  endtask
  task automatic rst(input logic por);
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    if (por) i_por_b <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    i_por_b <= 1'b1;
  endtask
  // ***************
  // scenarios
  // ***************
  initial begin
    void'($urandom(32'he3aa3c46));
    rst(1'b1);
    rdr(LVP_OFS_CTRL1);
    chk("ctrl1_reset", rd, 32'h0000_001C);
    rdr(LVP_OFS_CTRL2);
    chk("ctrl2_reset", rd, 32'h0000_0000);
    chk("detect_active", o_detect_active, 1'b1);
    rdr(8'h14);
    chk("unmapped_rd", {rs, rd[29:0]}, {LVP_RESP_SLVERR, 30'h0000_0000});
    wr(8'h14, 8'hFF);
    chk("unmapped_wr", rs, LVP_RESP_SLVERR);
    wr(LVP_OFS_CTRL1, 8'h35);
    settle(1);
    chk("ref_buf_on", o_reference_buffer_en, 1'b1);
    wr(LVP_OFS_CTRL1, 8'h00);
    rdr(LVP_OFS_CTRL1);
    chk("ctrl1_once", rd, 32'h0000_0014);
    chk("ref_buf_off", o_reference_buffer_en, 1'b0);
    wr(LVP_OFS_CTRL1, 8'h21);
    wr(LVP_OFS_IRQ_EN, 8'h01);
    sup(16'h0A8C);
    chk("warn_irq", {o_supply_warning_irq, o_irq}, 2'b11);
    wr(LVP_OFS_CTRL1, 8'h61);
    rdr(LVP_OFS_CTRL1);
    chk("ack_present", rd, 32'h0000_00B5);
    wr(LVP_OFS_IRQ_EN, 8'h00);
    settle(1);
    chk("irq_masked", {o_supply_warning_irq, o_irq}, 2'b10);
    rdr(LVP_OFS_IRQ_STAT);
    chk("irq_status", rd, 32'h0000_0001);
    wr(LVP_OFS_IRQ_CLR, 8'h01);
    rdr(LVP_OFS_IRQ_STAT);
    chk("irq_cleared", rd, 32'h0000_0000);
    sup(16'h0CE4);
    wr(LVP_OFS_CTRL1, 8'h61);
    rdr(LVP_OFS_CTRL1);
    chk("ack_clears", rd, 32'h0000_0035);
    chk("warn_irq_off", o_supply_warning_irq, 1'b0);
    sup(16'h09C4);
    chk("detect_reset", o_detect_reset, 1'b1);
    @(posedge i_mclk);
    i_stop_mode <= 1'b1;
    settle(5);
    chk("stop_no_detect", {o_detect_active, o_detect_reset}, 2'b00);
    @(posedge i_mclk);
    i_stop_mode <= 1'b0;
    sup(16'h1388);
    wr(LVP_OFS_CTRL2, 8'h31);
    settle(1);
    chk("ctrl2_first", {o_warning_level_code, o_detect_level_select, o_deep_stop_select}, 4'hF);
    wr(LVP_OFS_CTRL2, 8'h00);
    rdr(LVP_OFS_CTRL2);
    chk("ctrl2_once", rd, 32'h0000_0021);
    chk("level_code", o_warning_level_code, 2'b10);
    for (int i = 0; i < 8; i++) begin
      lvl = 1'($urandom_range(1, 0));
      mv = 16'($urandom_range(4900, 2500));
      wr(LVP_OFS_CTRL2, lvl ? 8'h10 : 8'h00);
      sup(mv);
      chk("rand_code", o_warning_level_code, {1'b1, lvl});
      wr(LVP_OFS_CTRL1, 8'h61);
      rdr(LVP_OFS_CTRL1);
      chk("rand_flag", rd[7], warn_exp(mv, {1'b1, lvl}));
    end
    @(posedge i_mclk);
    i_stop2_recover <= 1'b1;
    @(posedge i_mclk);
    i_stop2_recover <= 1'b0;
    settle(3);
    rdr(LVP_OFS_CTRL2);
    chk("ppd_flag", rd[3], 1'b1);
    rdr(LVP_OFS_IRQ_STAT);
    chk("irq_events", rd, 32'h0000_0007);
    wr(LVP_OFS_IRQ_EN, 8'h04);
    settle(1);
    chk("ppd_irq", o_irq, 1'b1);
    wr(LVP_OFS_IRQ_CLR, 8'h04);
    settle(1);
    chk("ppd_irq_clr", o_irq, 1'b0);
    wr(LVP_OFS_CTRL2, 8'h0C);
    rdr(LVP_OFS_CTRL2);
    chk("ppd_ack", rd, 32'h0000_0021);
    sup(16'h1388);
    rst(1'b0);
    rdr(LVP_OFS_CTRL2);
    chk("sysrst_ctrl2", rd, 32'h0000_0001);
    wr(LVP_OFS_CTRL2, 8'h00);
    settle(1);
    chk("deep_locked", o_deep_stop_select, 1'b1);
    wr(LVP_OFS_CTRL1, 8'h10);
    sup(16'h09C4);
    chk("detect_off", {o_detect_active, o_detect_reset}, 2'b00);
    rdr(LVP_OFS_CTRL1);
    chk("ctrl1_bits", rd[6:0], 7'h10);
    rst(1'b1);
    rdr(LVP_OFS_CTRL2);
    chk("por_ctrl2", {rd[31:4], rd[2:0], o_deep_stop_select}, 32'h0000_0000);
    rdr(LVP_OFS_CTRL1);
    chk("flag_after_rst", rd, 32'h0000_009C);
    close_out();
  end
endmodule
